// file: core/oag_core.v
// Operand address generation: mode decode and effective address sequencing
`include "oag_map.vh"
module oag_core #(
	parameter PC_W = 16
) (
	input wire ref_clk_i,
	input wire srst_i,
	input wire start_i,
	input wire [2:0] mode_i,
	input wire [2:0] op_i,
	input wire rsel_wreg_i,
	input wire [7:0] rsel_i,
	input wire [7:0] isel_i,
	input wire ptr_pair_i,
	input wire idx_long_i,
	input wire [15:0] field_i,
	input wire [PC_W-1:0] pc_next_i,
	input wire rf_rvalid_i,
	input wire [7:0] rf_rdata_i,
	output reg rf_rd_o,
	output reg [7:0] rf_addr_o,
	output reg done_o,
	output reg illegal_o,
	output reg [1:0] space_o,
	output reg [15:0] ea_o,
	output reg op_valid_o,
	output reg [7:0] operand_o,
	output reg pc_load_o,
	output reg [PC_W-1:0] pc_o
);
	localparam ST_IDLE = `OAG_ST_IDLE;
	localparam ST_RD1 = `OAG_ST_RD1;
	localparam ST_RD2 = `OAG_ST_RD2;
	localparam ST_RD3 = `OAG_ST_RD3;

	// Mode legality per instruction class
	function legal;
		input [2:0] md;
		input [2:0] op;
		begin
			case (md)
				`OAG_MODE_IDX: legal = (op == `OAG_OP_LOAD_REG) ||
					(op == `OAG_OP_LOAD_PROG) || (op == `OAG_OP_LOAD_EXT); // RQ10
				`OAG_MODE_DIR: legal = (op == `OAG_OP_LOAD_PROG) || (op == `OAG_OP_LOAD_EXT) ||
					(op == `OAG_OP_ABS_JUMP) || (op == `OAG_OP_SUB_BRANCH); // RQ11 RQ12
				`OAG_MODE_REL: legal = (op == `OAG_OP_REL_JUMP); // RQ14
				`OAG_MODE_REG, `OAG_MODE_WREG, `OAG_MODE_PTR, `OAG_MODE_CONST:
					legal = (op != `OAG_OP_REL_JUMP) && (op != `OAG_OP_ABS_JUMP) &&
						(op != `OAG_OP_SUB_BRANCH);
				default: legal = 1'b0; // RQ1
			endcase
		end
	endfunction

	// Memory space for pointer, indexed and direct loads
	function [1:0] mem_space;
		input [2:0] op;
		begin
			case (op)
				`OAG_OP_LOAD_PROG: mem_space = `OAG_SPC_PROG;
				`OAG_OP_LOAD_EXT: mem_space = `OAG_SPC_EXT;
				default: mem_space = `OAG_SPC_REG;
			endcase
		end
	endfunction

	reg [1:0] st_ff;
	reg [2:0] mode_ff;
	reg [2:0] op_ff;
	reg pair_ff;
	reg long_ff;
	reg [15:0] field_ff;
	reg [7:0] hi_ff;
	reg [1:0] nxt_st;
	wire [7:0] rsel_addr;
	wire [7:0] isel_addr;
	wire [PC_W-1:0] rel_sum;
	wire [15:0] pair_word;
	wire [15:0] ext_off;

	// Named register, with working field mapping and pair alignment
	// Working mode always maps into the window; pair alignment only matters for pointers
	oag_reg_addr u_rsel (
		.is_wreg_i(rsel_wreg_i || mode_i == `OAG_MODE_WREG), // RQ3
		.raw_i(rsel_i),
		.pair_i(ptr_pair_i && mode_i == `OAG_MODE_PTR), // RQ5
		.addr_o(rsel_addr)
	);

	// Index operand is always a working register or working pair
	oag_reg_addr u_isel (
		.is_wreg_i(1'b1),
		.raw_i(isel_i),
		.pair_i(mode_i == `OAG_MODE_IDX && op_i != `OAG_OP_LOAD_REG),
		.addr_o(isel_addr)
	);

	// Displacement sign-extended to PC width before the add
	assign rel_sum = pc_next_i + {{(PC_W-8){field_i[7]}}, field_i[7:0]}; // RQ13 RQ19
	// Even register read first gives the high byte
	assign pair_word = {hi_ff, rf_rdata_i}; // RQ16
	// Short offset is signed; long offset used whole
	assign ext_off = long_ff ? field_ff : {{8{field_ff[7]}}, field_ff[7:0]}; // RQ7 RQ9

	// Sequencer: one register file read per byte, waits on rvalid
	always @* begin
		nxt_st = st_ff;
		case (st_ff)
			ST_IDLE: begin
				if (start_i && legal(mode_i, op_i) && (mode_i == `OAG_MODE_REG ||
					mode_i == `OAG_MODE_WREG || mode_i == `OAG_MODE_PTR ||
					mode_i == `OAG_MODE_IDX))
					nxt_st = ST_RD1;
			end
			ST_RD1: begin
				if (rf_rvalid_i)
					nxt_st = ((mode_ff == `OAG_MODE_PTR && pair_ff) ||
						(mode_ff == `OAG_MODE_IDX && op_ff != `OAG_OP_LOAD_REG)) ?
						ST_RD2 : ST_IDLE;
			end
			ST_RD2: begin
				if (rf_rvalid_i)
					nxt_st = ST_IDLE;
			end
			default: nxt_st = ST_IDLE;
		endcase
	end

	// Registered outputs and captured instruction fields
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			st_ff <= ST_IDLE;
			mode_ff <= `OAG_MODE_REG;
			op_ff <= `OAG_OP_LOAD_REG;
			pair_ff <= 1'b0;
			long_ff <= 1'b0;
			field_ff <= 16'h0000;
			hi_ff <= 8'h00;
			rf_rd_o <= 1'b0;
			rf_addr_o <= 8'h00;
			done_o <= 1'b0;
			illegal_o <= 1'b0;
			space_o <= `OAG_SPC_NONE;
			ea_o <= 16'h0000;
			op_valid_o <= 1'b0;
			operand_o <= 8'h00;
			pc_load_o <= 1'b0;
			pc_o <= {PC_W{1'b0}};
		end else begin
			st_ff <= nxt_st;
			rf_rd_o <= 1'b0;
			done_o <= 1'b0;
			illegal_o <= 1'b0;
			op_valid_o <= 1'b0;
			pc_load_o <= 1'b0;
			case (st_ff)
				ST_IDLE: begin
					if (start_i) begin
						mode_ff <= mode_i;
						op_ff <= op_i;
						pair_ff <= ptr_pair_i;
						long_ff <= idx_long_i;
						field_ff <= field_i;
						if (!legal(mode_i, op_i)) begin
							illegal_o <= 1'b1; // RQ1
							done_o <= 1'b1;
							space_o <= `OAG_SPC_NONE;
						end else begin
							case (mode_i)
								`OAG_MODE_REG, `OAG_MODE_WREG: begin
									// Operand is the named register content
									rf_rd_o <= 1'b1; // RQ2 RQ3
									rf_addr_o <= rsel_addr;
								end
								`OAG_MODE_PTR: begin
									// Read pointer register (even byte first for pairs)
									rf_rd_o <= 1'b1; // RQ4 RQ5
									rf_addr_o <= rsel_addr;
								end
								`OAG_MODE_IDX: begin
									// Fetch offset or base from working register(s)
									rf_rd_o <= 1'b1; // RQ6 RQ8 RQ9
									rf_addr_o <= isel_addr;
								end
								`OAG_MODE_DIR: begin
									done_o <= 1'b1;
									ea_o <= field_i; // RQ11 RQ12
									if (op_i == `OAG_OP_ABS_JUMP || op_i == `OAG_OP_SUB_BRANCH) begin
										pc_load_o <= 1'b1; // RQ11
										pc_o <= field_i[PC_W-1:0];
										space_o <= `OAG_SPC_NONE;
									end else
										space_o <= mem_space(op_i); // RQ12
								end
								`OAG_MODE_REL: begin
									done_o <= 1'b1;
									pc_load_o <= 1'b1; // RQ13
									pc_o <= rel_sum;
									space_o <= `OAG_SPC_NONE;
								end
								default: begin
									// Constant: no memory access at all
									done_o <= 1'b1;
									op_valid_o <= 1'b1; // RQ15
									operand_o <= field_i[7:0];
									space_o <= `OAG_SPC_NONE;
								end
							endcase
						end
					end
				end
				ST_RD1: begin
					if (rf_rvalid_i) begin
						hi_ff <= rf_rdata_i;
						if (nxt_st == ST_RD2) begin
							// Second byte of a pair sits at the odd address
							rf_rd_o <= 1'b1; // RQ16
							rf_addr_o <= {rf_addr_o[7:1], 1'b1};
						end else begin
							done_o <= 1'b1;
							case (mode_ff)
								`OAG_MODE_PTR: begin
									space_o <= `OAG_SPC_REG; // RQ5
									ea_o <= {8'h00, rf_rdata_i};
								end
								`OAG_MODE_IDX: begin
									space_o <= `OAG_SPC_REG;
									ea_o <= {8'h00, field_ff[7:0] + rf_rdata_i}; // RQ8 RQ18
								end
								default: begin
									op_valid_o <= 1'b1; // RQ2
									operand_o <= rf_rdata_i;
									space_o <= `OAG_SPC_REG;
									ea_o <= {8'h00, rf_addr_o};
								end
							endcase
						end
					end
				end
				ST_RD2: begin
					if (rf_rvalid_i) begin
						done_o <= 1'b1;
						space_o <= mem_space(op_ff); // RQ4
						if (mode_ff == `OAG_MODE_IDX)
							ea_o <= pair_word + ext_off; // RQ9
						else
							ea_o <= pair_word; // RQ5
					end
				end
				default: begin
					done_o <= 1'b0;
				end
			endcase
		end
	end
endmodule

// file: core/oag_map.vh
// Constants for the operand address generation block
// Operation
// RQ1: Six operand modes: register, pointer, indexed, direct, relative, constant; subsets per instruction.
// RQ2: Register mode operand is the content of the named register.
// RQ3: Working register mode picks one of 16 bytes by a 4-bit field.
// RQ4: Pointer mode uses register or pair content as address in chosen space.
// RQ5: Any 8-bit register points to a register; any pair points to memory; the code gives register space for a pair with load_register or alu.
// RQ6: Indexed mode adds an offset to a base to form the address.
// RQ7: Short offset indexing is external only, displacement signed -128 to +127; the code also takes a short offset for program loads.
// RQ8: Register file indexing adds instruction base to working register offset.
// RQ9: External indexing adds 8 or 16-bit offset to named working pair.
// RQ10: Only load_register indexes register file; memory loads index program/external.
// RQ11: Direct mode carries 16-bit address; jumps and subroutine branches load PC.
// RQ12: Memory loads accept direct mode for program or external data memory.
// RQ13: Relative mode adds signed displacement to PC of next instruction.
// RQ14: Relative mode is available only to relative_jump.
// RQ15: Constant mode operand comes from the instruction field, no memory access.
// RQ16: Register pairs start at even address; even holds MSB, odd LSB.
// RQ17: Working registers occupy C0H-CFH; 4-bit field maps onto those.
// RQ18: Register file indexed sum wraps to 8 bits.
// RQ19: Relative sum sign-extends displacement to PC width, two's complement add.
`ifndef OAG_MAP_VH
`define OAG_MAP_VH
// Addressing modes
`define OAG_MODE_REG 3'h0
`define OAG_MODE_WREG 3'h1
`define OAG_MODE_PTR 3'h2
`define OAG_MODE_IDX 3'h3
`define OAG_MODE_DIR 3'h4
`define OAG_MODE_REL 3'h5
`define OAG_MODE_CONST 3'h6
// Instruction classes
`define OAG_OP_LOAD_REG 3'h0
`define OAG_OP_LOAD_PROG 3'h1
`define OAG_OP_LOAD_EXT 3'h2
`define OAG_OP_ABS_JUMP 3'h3
`define OAG_OP_SUB_BRANCH 3'h4
`define OAG_OP_REL_JUMP 3'h5
`define OAG_OP_ALU 3'h6
// Target spaces
`define OAG_SPC_NONE 2'h0
`define OAG_SPC_REG 2'h1
`define OAG_SPC_PROG 2'h2
`define OAG_SPC_EXT 2'h3
// Working register window base, upper nibble of C0H
`define OAG_WREG_HI 4'hC
// Pair even bit position
`define OAG_PAIR_LSB 0
// Sequencer states
`define OAG_ST_IDLE 2'h0
`define OAG_ST_RD1 2'h1
`define OAG_ST_RD2 2'h2
`define OAG_ST_RD3 2'h3
`endif

// file: core/oag_reg_addr.v
// Register file address helper: working and pair address forming
`include "oag_map.vh"
module oag_reg_addr (
	input wire is_wreg_i,
	input wire [7:0] raw_i,
	input wire pair_i,
	output wire [7:0] addr_o
);
	wire [7:0] base;
	// Working field maps into C0H-CFH
	assign base = is_wreg_i ? {`OAG_WREG_HI, raw_i[3:0]} : raw_i; // RQ3 RQ17
	// Pairs always begin on the even register
	assign addr_o = pair_i ? {base[7:1], 1'b0} : base; // RQ16
endmodule

// file: test/oag_core_chk.sv
// Concurrent checks on the operand address generator ports
module oag_core_chk #(parameter PC_W = 16) (
	input wire ref_clk_i,
	input wire srst_i,
	input wire start_i,
	input wire [2:0] mode_i,
	input wire [2:0] op_i,
	input wire [7:0] rsel_i,
	input wire [7:0] isel_i,
	input wire [15:0] field_i,
	input wire [PC_W-1:0] pc_next_i,
	input wire rf_rd_o,
	input wire [7:0] rf_addr_o,
	input wire done_o,
	input wire illegal_o,
	input wire [1:0] space_o,
	input wire [15:0] ea_o,
	input wire [7:0] operand_o,
	input wire pc_load_o,
	input wire [PC_W-1:0] pc_o
);
	timeunit 1ns;
	timeprecision 1ps;
	reg busy_ff = 1'h0;
	wire tk = start_i && !busy_ff;
	wire [5:0] mo = {mode_i, op_i};
	wire [PC_W-1:0] rp = pc_next_i + {{(PC_W-8){field_i[7]}}, field_i[7:0]};
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	// A start only counts while nothing is in flight, as the design drops the rest
	always @(posedge ref_clk_i) busy_ff <= srst_i ? 1'h0 : (busy_ff ? !done_o : start_i);
	AST_REL: assert property (tk && mo == 6'h2D |=>
		pc_load_o && done_o && pc_o == $past(rp)) else $error("relative target wrong");
	AST_REL_ONLY: assert property (tk && mode_i == 3'h5 && op_i != 3'h5 |=>
		illegal_o && done_o && !pc_load_o) else $error("relative mode accepted");
	AST_JUMP: assert property (tk && (mo == 6'h23 || mo == 6'h24) |=>
		pc_load_o && pc_o == $past(field_i)) else $error("direct jump target wrong");
	AST_DIR_EXT: assert property (tk && mo == 6'h22 |=>
		done_o && ea_o == $past(field_i) && space_o == 2'h3) else $error("direct load wrong");
	AST_CONST: assert property (tk && mo == 6'h36 |=>
		operand_o == $past(field_i[7:0]) && !rf_rd_o) else $error("constant operand wrong");
	AST_WREG: assert property (tk && mo == 6'h0E |=>
		rf_rd_o && rf_addr_o == {4'hC, $past(rsel_i[3:0])}) else $error("working address wrong");
	AST_IDX_RD: assert property (tk && mo == 6'h18 |=>
		rf_rd_o && rf_addr_o == {4'hC, $past(isel_i[3:0])}) else $error("index offset read wrong");
	AST_IDX_ILL: assert property (tk && mode_i == 3'h3 && op_i > 3'h2 |=>
		illegal_o && !rf_rd_o) else $error("indexed mode accepted");
	cover property (pc_load_o);
	cover property (illegal_o);
	cover property (rf_rd_o ##[1:8] rf_rd_o);
endmodule
bind oag_core oag_core_chk #(.PC_W(PC_W)) u_chk (.*);

// file: test/oag_rf_model.sv
// Register file stand-in answering the generator's read requests
module oag_rf_model (
	input wire clk_i,
	input wire srst_i,
	input wire rd_i,
	input wire [7:0] addr_i,
	input wire slow_i,
	output logic rvalid_o,
	output logic [7:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] a_ff;
	int cnt;
	// Data is the address scrambled; stale data toggles so nothing reads a held byte
	always @(posedge clk_i) begin
		rvalid_o <= 1'h0;
		rdata_o <= ~rdata_o;
		if (srst_i) begin
			cnt <= 0;
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			a_ff <= addr_i;
			cnt <= slow_i ? 3 : 1;
		end else if (cnt == 1) begin
			rvalid_o <= 1'h1;
			rdata_o <= a_ff ^ 8'h5A;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// file: test/testbench.sv
// Self-checking bench for the operand address generator
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [2:0] m; logic [2:0] o; logic [15:0] f; logic i; logic [15:0] e;} oag_row_t;
	logic ref_clk_i = 0, srst_i = 1, start_i = 0, rsel_wreg_i = 0, ptr_pair_i = 0;
	logic idx_long_i = 0, slow = 0;
	logic [2:0] mode_i = 0, op_i = 0;
	logic [7:0] rsel_i = 0, isel_i = 0;
	logic [15:0] field_i = 0, pc_next_i = 16'h1000;
	wire rf_rvalid_i, rf_rd_o, done_o, illegal_o, op_valid_o, pc_load_o;
	wire [7:0] rf_rdata_i, rf_addr_o, operand_o;
	wire [1:0] space_o;
	wire [15:0] ea_o, pc_o;
	int num_errors = 0, checks_done = 0, cyc = 0;
	// Mode, class, field, refused, expected result
	oag_row_t rows [12] = '{'{3'h5, 3'h5, 16'h0080, 1'h0, 16'h0F80},
		'{3'h5, 3'h5, 16'h007F, 1'h0, 16'h107F}, '{3'h5, 3'h0, 16'h0001, 1'h1, 16'h0},
		'{3'h4, 3'h3, 16'hBEEF, 1'h0, 16'hBEEF}, '{3'h4, 3'h4, 16'h1234, 1'h0, 16'h1234},
		'{3'h4, 3'h1, 16'hABCD, 1'h0, 16'hABCD}, '{3'h4, 3'h2, 16'h4321, 1'h0, 16'h4321},
		'{3'h4, 3'h6, 16'h0, 1'h1, 16'h0}, '{3'h3, 3'h5, 16'h0, 1'h1, 16'h0},
		'{3'h6, 3'h6, 16'h00A5, 1'h0, 16'h00A5}, '{3'h6, 3'h3, 16'h0, 1'h1, 16'h0},
		'{3'h7, 3'h0, 16'h0, 1'h1, 16'h0}};
	oag_core dut (.*);
	oag_rf_model rf (.clk_i(ref_clk_i), .srst_i(srst_i), .rd_i(rf_rd_o), .addr_i(rf_addr_o),
		.slow_i(slow), .rvalid_o(rf_rvalid_i), .rdata_o(rf_rdata_i));
	task automatic chk(input string n, input logic [15:0] s, e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic print_verdict;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// One request, then a bounded wait for its completion pulse
	task automatic go(input logic [2:0] m, o, input logic [15:0] f, input logic [7:0] r,
		input logic w, p, l);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		#1 {mode_i, op_i, field_i, rsel_i, isel_i} = {m, o, f, r, r};
		{rsel_wreg_i, ptr_pair_i, idx_long_i, start_i} = {w, p, l, 1'h1};
		@(posedge ref_clk_i);
		#1 start_i = 0;
		while (done_o !== 1'h1 && n < 40) begin
			@(posedge ref_clk_i);
			#1 n++;
		end
		chk("done", {15'h0, done_o}, 16'h1);
	endtask
	initial forever #2 ref_clk_i = ~ref_clk_i;
	// Cuts a hang short; the tests need well under a thousand cycles
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			print_verdict;
		end
	end
	// Reset, table of single-cycle modes, then the register file reading cases
	initial begin
		int k;
		repeat (16) @(posedge ref_clk_i);
		#1 srst_i = 0;
		chk("reset pc", pc_o, 16'h0);
		chk("reset ea", ea_o, 16'h0);
		foreach (rows[i]) begin
			go(rows[i].m, rows[i].o, rows[i].f, 8'h00, 0, 0, 0);
			chk("illegal", {15'h0, illegal_o}, {15'h0, rows[i].i});
			if (rows[i].i) chk("no pc load", {15'h0, pc_load_o}, 16'h0);
			else if (rows[i].m == 3'h6) begin
				chk("operand", {8'h0, operand_o}, rows[i].e);
				chk("operand valid", {15'h0, op_valid_o}, 16'h1);
			end else if (rows[i].o > 3'h2) chk("pc", pc_o, rows[i].e);
			else begin
				chk("ea", ea_o, rows[i].e);
				chk("ea space", {14'h0, space_o}, (rows[i].o == 3'h1) ? 16'h2 : 16'h3);
			end
		end
		slow = 1;
		go(3'h2, 3'h1, 16'h0, 8'h05, 1, 1, 0);
		chk("pair ea", ea_o, 16'h9E9F);
		chk("pair space", {14'h0, space_o}, 16'h2);
		slow = 0;
		go(3'h3, 3'h0, 16'h00F0, 8'h03, 0, 0, 0);
		chk("idx reg", {8'h0, ea_o[7:0]}, 16'h0089);
		chk("idx reg space", {14'h0, space_o}, 16'h1);
		go(3'h3, 3'h2, 16'h0080, 8'h02, 0, 0, 0);
		chk("idx short", ea_o, 16'h9819);
		chk("idx short space", {14'h0, space_o}, 16'h3);
		go(3'h3, 3'h1, 16'h1000, 8'h02, 0, 0, 1);
		chk("idx long", ea_o, 16'hA899);
		go(3'h0, 3'h6, 16'h0, 8'h40, 0, 0, 0);
		chk("reg", {8'h0, operand_o}, 16'h001A);
		chk("reg valid", {15'h0, op_valid_o}, 16'h1);
		// A pair flag on a plain register read must not pull it to the even byte
		go(3'h0, 3'h6, 16'h0, 8'h41, 0, 1, 0);
		chk("reg odd", {8'h0, operand_o}, 16'h001B);
		go(3'h1, 3'h6, 16'h0, 8'h07, 1, 0, 0);
		chk("wreg", {8'h0, operand_o}, 16'h009D);
		// Working mode maps into the window even without the field flag
		go(3'h1, 3'h6, 16'h0, 8'h07, 0, 0, 0);
		chk("wreg mode", {8'h0, operand_o}, 16'h009D);
		go(3'h2, 3'h0, 16'h0, 8'h20, 0, 0, 0);
		chk("ptr", {8'h0, ea_o[7:0]}, 16'h007A);
		chk("ptr space", {14'h0, space_o}, 16'h1);
		// A start while a pair read is in flight is dropped, not queued
		slow = 1;
		@(posedge ref_clk_i);
		#1 {mode_i, op_i, rsel_i, rsel_wreg_i, ptr_pair_i} = {3'h2, 3'h2, 8'h0A, 1'h1, 1'h1};
		start_i = 1;
		@(posedge ref_clk_i);
		#1 start_i = 0;
		@(posedge ref_clk_i);
		#1 {mode_i, op_i, field_i, start_i} = {3'h4, 3'h3, 16'h5555, 1'h1};
		@(posedge ref_clk_i);
		#1 start_i = 0;
		k = 0;
		while (done_o !== 1'h1 && k < 40) begin
			@(posedge ref_clk_i);
			#1 k++;
		end
		chk("busy ea", ea_o, 16'h9091);
		chk("busy space", {14'h0, space_o}, 16'h3);
		chk("busy pc", pc_o, 16'h1234);
		// Reset in mid-read drops the request and clears every held result
		@(posedge ref_clk_i);
		#1 {mode_i, op_i, rsel_i, ptr_pair_i, start_i} = {3'h0, 3'h6, 8'h11, 1'h0, 1'h1};
		@(posedge ref_clk_i);
		#1 {start_i, srst_i} = 2'h1;
		@(posedge ref_clk_i);
		#1 srst_i = 0;
		repeat (8) @(posedge ref_clk_i);
		#1 chk("mid reset rd", {15'h0, rf_rd_o}, 16'h0);
		chk("mid reset operand", {8'h0, operand_o}, 16'h0);
		chk("mid reset ea", ea_o, 16'h0);
		chk("mid reset space", {14'h0, space_o}, 16'h0);
		slow = 0;
		// The block recovers fully after the cut sequence
		go(3'h6, 3'h0, 16'h003C, 8'h00, 0, 0, 0);
		chk("after reset", {8'h0, operand_o}, 16'h003C);
		print_verdict;
	end
endmodule
